// *** hw/ucs_cfg.svh ***
`ifndef UCS_CFG_SVH
`define UCS_CFG_SVH

`define UCS_AW 6
`define UCS_OFF_CTRL 6'h00
`define UCS_OFF_IMASK 6'h04
`define UCS_OFF_RIS 6'h08
`define UCS_OFF_MIS 6'h0c
`define UCS_OFF_ICR 6'h10
`define UCS_OFF_MSET 6'h14
`define UCS_OFF_MCLR 6'h18
`define UCS_OFF_MSTAT 6'h1c
`define UCS_OFF_RXERR 6'h20

`define UCS_CTRL_SMART 0
`define UCS_CTRL_TXFC 1
`define UCS_CTRL_RXFC 2
`define UCS_CTRL_PAR_LO 4
`define UCS_CTRL_PAR_HI 6

`define UCS_MC_DTR 0
`define UCS_MC_RTS 1

`define UCS_NIRQ 12
`define UCS_IRQ_RI 0
`define UCS_IRQ_DCD 1
`define UCS_IRQ_DSR 2
`define UCS_IRQ_CTS 3
`define UCS_IRQ_RX 4
`define UCS_IRQ_TX 5
`define UCS_IRQ_RT 6
`define UCS_IRQ_FE 7
`define UCS_IRQ_PE 8
`define UCS_IRQ_BE 9
`define UCS_IRQ_OE 10
`define UCS_IRQ_AM 11

`define UCS_ERR_FE 0
`define UCS_ERR_PE 1
`define UCS_ERR_BE 2
`define UCS_ERR_OE 3

`define UCS_RST_IMASK 12'h000
`define UCS_RST_RAW 12'h000
`define UCS_RST_ERR 4'h0

`endif

// *** hw/ucs_pkg.sv ***
package ucs_pkg;

    typedef enum logic [2:0] {
        parity_off = 3'b000,
        parity_even_sel = 3'b001,
        parity_odd_sel = 3'b010,
        parity_forced_high = 3'b011,
        parity_forced_low = 3'b100
    } ucs_par_t;

    // One-cycle event pulses from the character datapath.
    typedef struct packed {
        logic addr_match;
        logic overrun;
        logic brk;
        logic par_err;
        logic frm_err;
        logic rx_tmo;
        logic tx;
        logic rx;
    } ucs_evt_t;

    // Error bits that travel with a character as software reads it.
    typedef struct packed {
        logic brk;
        logic par;
        logic frm;
    } ucs_chr_err_t;

endpackage

// *** hw/ucs_modem_in.sv ***
module ucs_modem_in #(
    parameter int W = 4
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] raw_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] chg_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // The third stage only feeds the edge compare, so the first stage
    // is never looked at by anything but the second.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl_o = s2_q;
    assign chg_o = s2_q ^ s3_q;

endmodule

// *** hw/ucs_ctrl_status.sv ***
`include "ucs_cfg.svh"

module ucs_ctrl_status
    import ucs_pkg::*;
#(
    parameter int CHAR_W = 8
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [`UCS_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire ucs_evt_t evt_i,
    input wire logic chr_rd_i,
    input wire ucs_chr_err_t chr_err_i,
    input wire logic rx_chk_i,
    input wire logic [CHAR_W-1:0] rx_data_i,
    input wire logic rx_par_i,
    input wire logic [CHAR_W-1:0] tx_data_i,
    input wire logic tx_req_i,
    input wire logic rx_space_i,
    input wire logic ri_i,
    input wire logic dcd_i,
    input wire logic dsr_i,
    input wire logic cts_i,
    output logic irq_o,
    output logic dtr_o,
    output logic rts_o,
    output logic tx_go_o,
    output logic tx_par_o,
    output logic smart_en_o,
    output ucs_par_t par_mode_o
);

    function automatic logic par_bit(ucs_par_t m, logic [CHAR_W-1:0] d);
        case (m)
            parity_even_sel: par_bit = ^d;
            parity_odd_sel: par_bit = ~^d;
            parity_forced_high: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction

    function automatic logic par_legal(logic [2:0] c);
        par_legal = (c <= 3'h4);
    endfunction

    logic smart_q;
    logic txfc_q;
    logic rxfc_q;
    ucs_par_t mode_q;
    logic [`UCS_NIRQ-1:0] mask_q;
    logic [`UCS_NIRQ-1:0] raw_q;
    logic [`UCS_NIRQ-1:0] raw_d;
    logic [3:0] err_q;
    logic dtr_q;
    logic rts_sw_q;
    logic rts_q;
    logic irq_q;
    logic tx_go_q;
    logic tx_par_q;
    logic [31:0] rdata_q;
    logic [3:0] lvl;
    logic [3:0] chg;

    ucs_modem_in #(
        .W(4)
    ) u_modem (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .raw_i({cts_i, dsr_i, dcd_i, ri_i}),
        .lvl_o(lvl),
        .chg_o(chg)
    );

    wire wr_ctrl = wr_i && (addr_i == `UCS_OFF_CTRL);
    wire wr_imask = wr_i && (addr_i == `UCS_OFF_IMASK);
    wire wr_icr = wr_i && (addr_i == `UCS_OFF_ICR);
    wire wr_mset = wr_i && (addr_i == `UCS_OFF_MSET);
    wire wr_mclr = wr_i && (addr_i == `UCS_OFF_MCLR);
    wire wr_rxerr = wr_i && (addr_i == `UCS_OFF_RXERR);
    wire [2:0] wr_par = wdata_i[`UCS_CTRL_PAR_HI:`UCS_CTRL_PAR_LO];

    // A received character is checked against the same mode that
    // stamps the transmit parity bit.
    wire rx_pe = rx_chk_i && (mode_q != parity_off) &&
        (rx_par_i != par_bit(mode_q, rx_data_i));

    // An error source re-arms only once its error flag has been cleared.
    wire fe_new = evt_i.frm_err && !err_q[`UCS_ERR_FE];
    wire pe_new = (evt_i.par_err || rx_pe) && !err_q[`UCS_ERR_PE];
    wire be_new = evt_i.brk && !err_q[`UCS_ERR_BE];
    wire oe_new = evt_i.overrun && !err_q[`UCS_ERR_OE];

    wire [`UCS_NIRQ-1:0] set_vec = {evt_i.addr_match, oe_new, be_new,
        pe_new, fe_new, evt_i.rx_tmo, evt_i.tx, evt_i.rx, chg};
    wire [`UCS_NIRQ-1:0] clr_vec =
        wr_icr ? wdata_i[`UCS_NIRQ-1:0] : `UCS_RST_RAW;
    wire [`UCS_NIRQ-1:0] mis = raw_q & mask_q;

    // Set beats clear, so an event in the clearing cycle survives.
    // Modem changes land here whatever the mask says.
    assign raw_d = (raw_q & ~clr_vec) | set_vec;

    wire [31:0] rd_ctrl = {25'h0, mode_q, 1'b0, rxfc_q, txfc_q, smart_q};
    wire [31:0] rd_imask = {20'h0, mask_q};
    wire [31:0] rd_ris = {20'h0, raw_q};
    wire [31:0] rd_mis = {20'h0, mis};
    wire [31:0] rd_mc = {30'h0, rts_q, dtr_q};
    wire [31:0] rd_ms = {28'h0, lvl};
    wire [31:0] rd_err = {28'h0, err_q};
    wire [31:0] rd_mux =
        (addr_i == `UCS_OFF_CTRL) ? rd_ctrl :
        (addr_i == `UCS_OFF_IMASK) ? rd_imask :
        (addr_i == `UCS_OFF_RIS) ? rd_ris :
        (addr_i == `UCS_OFF_MIS) ? rd_mis :
        (addr_i == `UCS_OFF_MSET) ? rd_mc :
        (addr_i == `UCS_OFF_MSTAT) ? rd_ms :
        (addr_i == `UCS_OFF_RXERR) ? rd_err : 32'h0;

    wire rts_d = rxfc_q ? rx_space_i : rts_sw_q;
    wire tx_ok = !txfc_q || lvl[`UCS_IRQ_CTS];

    // An illegal parity code is dropped and the old mode kept.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            smart_q <= 1'b0;
            txfc_q <= 1'b0;
            rxfc_q <= 1'b0;
            mode_q <= parity_off;
        end else if (wr_ctrl) begin
            smart_q <= wdata_i[`UCS_CTRL_SMART];
            txfc_q <= wdata_i[`UCS_CTRL_TXFC];
            rxfc_q <= wdata_i[`UCS_CTRL_RXFC];
            if (par_legal(wr_par)) begin
                mode_q <= ucs_par_t'(wr_par);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_q <= `UCS_RST_IMASK;
            raw_q <= `UCS_RST_RAW;
            irq_q <= 1'b0;
        end else begin
            if (wr_imask) begin
                mask_q <= wdata_i[`UCS_NIRQ-1:0];
            end
            raw_q <= raw_d;
            irq_q <= |mis;
        end
    end

    // One process owns the whole error word, so it has a single driver.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_q <= `UCS_RST_ERR;
        end else begin
            if (chr_rd_i) begin
                err_q[2:0] <= {chr_err_i.brk, chr_err_i.par,
                    chr_err_i.frm};
            end else if (wr_rxerr) begin
                err_q[2:0] <= 3'h0;
            end
            // Overrun is flagged as it happens, not when a character is read.
            if (evt_i.overrun) begin
                err_q[`UCS_ERR_OE] <= 1'b1;
            end else if (wr_rxerr) begin
                err_q[`UCS_ERR_OE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dtr_q <= 1'b0;
            rts_sw_q <= 1'b0;
        end else if (wr_mset) begin
            dtr_q <= dtr_q | wdata_i[`UCS_MC_DTR];
            rts_sw_q <= rts_sw_q | wdata_i[`UCS_MC_RTS];
        end else if (wr_mclr) begin
            dtr_q <= dtr_q & ~wdata_i[`UCS_MC_DTR];
            rts_sw_q <= rts_sw_q & ~wdata_i[`UCS_MC_RTS];
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rts_q <= 1'b0;
            tx_go_q <= 1'b0;
            tx_par_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            rts_q <= rts_d;
            tx_go_q <= tx_req_i && tx_ok;
            tx_par_q <= par_bit(mode_q, tx_data_i);
            rdata_q <= rd_i ? rd_mux : 32'h0;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign dtr_o = dtr_q;
    assign rts_o = rts_q;
    assign tx_go_o = tx_go_q;
    assign tx_par_o = tx_par_q;
    assign smart_en_o = smart_q;
    assign par_mode_o = mode_q;

    // Helper: bits that must still be pending one cycle on.
    logic [`UCS_NIRQ-1:0] keep_q;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            keep_q <= `UCS_RST_RAW;
        end else begin
            keep_q <= raw_q & ~clr_vec;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    chk_irq_masked: assert property (
        (mis == 12'h0) |=> !irq_o)
        else $error("Interrupt raised with no enabled source.");

    chk_irq_source: assert property (
        evt_i.rx |=> raw_q[`UCS_IRQ_RX] ##1
        (irq_o || !$past(mask_q[`UCS_IRQ_RX])))
        else $error("Receive event did not reach the interrupt.");

    chk_mis_read: assert property (
        rd_i && addr_i == `UCS_OFF_MIS |=>
        rdata_o[11:0] == ($past(raw_q) & $past(mask_q)))
        else $error("Masked status read is wrong.");

    chk_raw_hold: assert property (
        1'b1 |-> ((raw_q & keep_q) == keep_q))
        else $error("Pending source dropped without a clear.");

    chk_raw_clear: assert property (
        wr_icr && wdata_i[`UCS_IRQ_RI] && !chg[0] |=> !raw_q[`UCS_IRQ_RI])
        else $error("Clear write left the source pending.");

    chk_dtr_set: assert property (
        wr_mset && wdata_i[`UCS_MC_DTR] |=> dtr_o ##1
        (dtr_o || $past(wr_mclr) && $past(wdata_i[`UCS_MC_DTR])))
        else $error("DTR not asserted by a set write.");

    chk_dtr_keep: assert property (
        wr_mclr && !wdata_i[`UCS_MC_DTR] |=> $stable(dtr_o))
        else $error("DTR moved on a write for RTS only.");

    chk_mc_read: assert property (
        rd_i && addr_i == `UCS_OFF_MSET |=>
        rdata_o[1:0] == {$past(rts_o), $past(dtr_o)})
        else $error("Handshake output read is wrong.");

    chk_ms_read: assert property (
        rd_i && addr_i == `UCS_OFF_MSTAT |=> rdata_o[3:0] == $past(lvl))
        else $error("Modem input read is wrong.");

    chk_par_read: assert property (
        wr_ctrl && wr_par == 3'h2 ##1 rd_i && addr_i == `UCS_OFF_CTRL
        |=> rdata_o[6:4] == 3'h2)
        else $error("Parity mode does not read back.");

    chk_par_forced: assert property (
        mode_q == parity_forced_high ##1 mode_q == parity_forced_high
        |-> tx_par_o)
        else $error("Forced-one parity bit not one.");

    chk_par_even: assert property (
        mode_q == parity_even_sel |=> tx_par_o == ^$past(tx_data_i))
        else $error("Even parity bit does not match the data.");

    chk_par_check: assert property (
        rx_chk_i && mode_q == parity_odd_sel && rx_par_i == ^rx_data_i &&
        !err_q[`UCS_ERR_PE] |=> raw_q[`UCS_IRQ_PE])
        else $error("Odd parity mismatch was not flagged.");

    chk_err_read: assert property (
        rd_i && addr_i == `UCS_OFF_RXERR |=> rdata_o[3:0] == $past(err_q))
        else $error("Error status read is wrong.");

    chk_ovr_set: assert property (
        evt_i.overrun |=> err_q[`UCS_ERR_OE] && raw_q[`UCS_IRQ_OE] ||
        $past(err_q[`UCS_ERR_OE]))
        else $error("Overrun did not set its flag at once.");

    chk_frm_load: assert property (
        chr_rd_i |=> err_q[`UCS_ERR_FE] == $past(chr_err_i.frm))
        else $error("Framing flag does not follow the read character.");

    chk_err_clear: assert property (
        wr_rxerr && !chr_rd_i && !evt_i.overrun |=> err_q == 4'h0)
        else $error("Error clear write left a flag set.");

    chk_err_gate: assert property (
        err_q[`UCS_ERR_FE] && !raw_q[`UCS_IRQ_FE] |=> !raw_q[`UCS_IRQ_FE])
        else $error("Framing interrupt re-raised before flag clear.");

    chk_smart_wr: assert property (
        wr_ctrl |=> smart_en_o == $past(wdata_i[`UCS_CTRL_SMART]))
        else $error("Smart card enable not taken from the write.");

    chk_cts_gate: assert property (
        txfc_q && !lvl[`UCS_IRQ_CTS] |=> !tx_go_o)
        else $error("Transmit started while CTS deasserted.");

    chk_rts_space: assert property (
        rxfc_q && !rx_space_i |=> !rts_o)
        else $error("RTS asserted with no receive space.");

    chk_modem_chg: assert property (
        chg[`UCS_IRQ_DCD] |=> raw_q[`UCS_IRQ_DCD])
        else $error("Carrier change did not set its pending flag.");

    cov_irq_rise: cover property (!irq_o ##1 irq_o);
    cov_overrun: cover property (evt_i.overrun ##1 err_q[`UCS_ERR_OE]);
    cov_cts_stall: cover property (txfc_q && tx_req_i && !tx_ok);
    cov_err_clear: cover property (err_q != 4'h0 ##1 wr_rxerr);
    cov_par_err: cover property (rx_pe && mode_q == parity_odd_sel);

endmodule

// *** sim/ucs_modem_model.sv ***
// Remote modem: moves its status lines to the wanted levels after a delay.
module ucs_modem_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] want_i,
    input wire logic [3:0] dly_i,
    output logic [3:0] line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] line_q;
    logic [3:0] cnt_q;
    assign line_o = line_q;
    // A slow modem is modelled by a long delay, so late edges get exercised.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_q <= 4'h0;
            cnt_q <= 4'h0;
        end else if (want_i == line_q) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= dly_i) begin
            line_q <= want_i;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// *** sim/tb.sv ***
`include "ucs_cfg.svh"
module tb
    import ucs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, resetn_i, wr, rd, chr_rd, rx_chk, rx_par, tx_req;
    logic rx_space, irq, dtr, rts, txgo, txpar, smart, sd, sr, mm;
    logic [5:0] addr;
    logic [31:0] wdata, rdata, m, w, pm;
    logic [7:0] rxd, txd;
    logic [3:0] want, dly, line, old;
    logic [1:0] f;
    ucs_evt_t evt;
    ucs_chr_err_t cerr;
    ucs_par_t pmode;
    int fail_count, num_checks, cyc;

    ucs_modem_model model (.clk_i(core_clk_i), .rstn_i(resetn_i),
        .want_i(want), .dly_i(dly), .line_o(line));
    ucs_ctrl_status dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .evt_i(evt), .chr_rd_i(chr_rd), .chr_err_i(cerr),
        .rx_chk_i(rx_chk), .rx_data_i(rxd), .rx_par_i(rx_par),
        .tx_data_i(txd), .tx_req_i(tx_req), .rx_space_i(rx_space),
        .ri_i(line[0]), .dcd_i(line[1]), .dsr_i(line[2]), .cts_i(line[3]),
        .irq_o(irq), .dtr_o(dtr), .rts_o(rts), .tx_go_o(txgo),
        .tx_par_o(txpar), .smart_en_o(smart), .par_mode_o(pmode));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    function automatic logic par_bit(input logic [31:0] md, logic [7:0] v);
        case (md)
            32'h1: return ^v;
            32'h2: return ~^v;
            32'h3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wreg(input logic [5:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(negedge core_clk_i);
        chk($sformatf("reg %h", a), e, rdata);
    endtask

    // Write then read at once, with no idle cycle between the strobes.
    task automatic wrrd(input logic [5:0] a, input logic [31:0] v, e);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(negedge core_clk_i);
        chk($sformatf("reg %h", a), e, rdata);
    endtask

    // Two edges cover the slowest output path of one cycle after a register.
    task automatic settle();
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    task automatic pulse(input ucs_evt_t e);
        @(posedge core_clk_i);
        evt <= e;
        @(posedge core_clk_i);
        evt <= '0;
        settle();
    endtask

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        {resetn_i, wr, rd, chr_rd, rx_chk, rx_par, tx_req, rx_space} = '0;
        {addr, wdata, rxd, txd, want, dly, evt, cerr} = '0;
        {sd, sr} = 2'b00;
        void'($urandom(32'hc1868a28));
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rchk(`UCS_OFF_CTRL, 32'h0);
        rchk(`UCS_OFF_IMASK, 32'h0);
        rchk(`UCS_OFF_RXERR, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            m = $urandom & 32'hfff;
            wreg(`UCS_OFF_IMASK, m);
            pulse(ucs_evt_t'(8'h1 << i));
            rchk(`UCS_OFF_RIS, 32'h10 << i);
            rchk(`UCS_OFF_MIS, (32'h10 << i) & m);
            chk("irq", m[i+4], irq);
            wreg(`UCS_OFF_ICR, 32'h10 << i);
            wreg(`UCS_OFF_RXERR, 32'h0);
            settle();
            rchk(`UCS_OFF_RIS, 32'h0);
            chk("irq", 32'h0, irq);
        end
        $display("test sources done");
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_i);
            cerr <= ucs_chr_err_t'(3'($urandom));
            chr_rd <= 1'b1;
            @(posedge core_clk_i);
            chr_rd <= 1'b0;
            rchk(`UCS_OFF_RXERR, {29'h0, cerr});
        end
        wreg(`UCS_OFF_RXERR, 32'h0);
        rchk(`UCS_OFF_RXERR, 32'h0);
        pulse(ucs_evt_t'(8'h40));
        rchk(`UCS_OFF_RXERR, 32'h8);
        wreg(`UCS_OFF_ICR, 32'h400);
        pulse(ucs_evt_t'(8'h40));
        rchk(`UCS_OFF_RIS, 32'h0);
        wreg(`UCS_OFF_RXERR, 32'h0);
        pulse(ucs_evt_t'(8'h40));
        rchk(`UCS_OFF_RIS, 32'h400);
        wreg(`UCS_OFF_ICR, 32'h400);
        wreg(`UCS_OFF_RXERR, 32'h0);
        $display("test errors done");
        wreg(`UCS_OFF_IMASK, 32'h0);
        for (int i = 0; i < 6; i++) begin
            old = line;
            @(posedge core_clk_i);
            want <= 4'($urandom);
            dly <= 4'($urandom);
            repeat (24) @(posedge core_clk_i);
            rchk(`UCS_OFF_MSTAT, {28'h0, want});
            rchk(`UCS_OFF_RIS, {28'h0, old ^ want});
            chk("irq masked", 32'h0, irq);
            wreg(`UCS_OFF_ICR, 32'hf);
        end
        $display("test modem inputs done");
        for (int i = 0; i < 8; i++) begin
            w = $urandom & 32'h3;
            if ($urandom & 1) begin
                wreg(`UCS_OFF_MSET, w);
                {sr, sd} = {sr, sd} | w[1:0];
            end else begin
                wreg(`UCS_OFF_MCLR, w);
                {sr, sd} = {sr, sd} & ~w[1:0];
            end
            settle();
            chk("dtr", sd, dtr);
            chk("rts", sr, rts);
            rchk(`UCS_OFF_MSET, {30'h0, sr, sd});
        end
        $display("test modem outputs done");
        pm = 32'h0;
        for (int k = 0; k < 6; k++) begin
            // Codes above forced zero are refused and keep the old mode.
            if (k < 5) pm = k;
            wrrd(`UCS_OFF_CTRL, k << 4, pm << 4);
            settle();
            chk("mode", pm, pmode);
            for (int j = 0; j < 4; j++) begin
                @(posedge core_clk_i);
                txd <= 8'($urandom);
                rxd <= 8'($urandom);
                rx_par <= 1'($urandom);
                rx_chk <= 1'b1;
                @(posedge core_clk_i);
                rx_chk <= 1'b0;
                settle();
                chk("tx parity", par_bit(pm, txd), txpar);
                mm = (pm != 0) && (par_bit(pm, rxd) != rx_par);
                rchk(`UCS_OFF_RIS, {23'h0, mm, 8'h0});
                wreg(`UCS_OFF_ICR, 32'h100);
            end
        end
        $display("test parity done");
        wreg(`UCS_OFF_CTRL, 32'h11);
        settle();
        chk("smart on", 32'h1, smart);
        wreg(`UCS_OFF_CTRL, 32'h0);
        settle();
        chk("smart off", 32'h0, smart);
        $display("test smart card done");
        for (int i = 0; i < 8; i++) begin
            f = 2'($urandom);
            wreg(`UCS_OFF_CTRL, {29'h0, f, 1'b0});
            @(posedge core_clk_i);
            want <= {1'($urandom), 3'b000};
            tx_req <= 1'($urandom);
            rx_space <= 1'($urandom);
            repeat (24) @(posedge core_clk_i);
            @(negedge core_clk_i);
            chk("tx go", tx_req & (!f[0] | want[3]), txgo);
            chk("rts flow", f[1] ? rx_space : sr, rts);
        end
        $display("test flow control done");
        end_sim();
    end
endmodule
